// file: design/spis_pin_sampler.sv
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "spis_defs.svh"

module spis_pin_sampler
(
    input  wire logic              mclk_in,
    input  wire logic              rst_b_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [11:0]       paddr_in,
    input  wire logic [31:0]       pwdata_in,
    input  wire logic [3:0]        pstrb_in,
    input  wire logic              target_out_data_line_in,
    input  wire logic              controller_out_data_line_in,
    input  wire logic              serial_clock_line_in,
    input  wire logic              enable_handshake_line_in,
    input  wire spis_pkg::spis_sel_t target_select_line_in,
    output logic [31:0]            prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out
);

////////////////////////////////////////////////////////////////////////////////
// synchronisers: each pin level passes two flops before software may see it

    logic                      tgt_out_sync;
    logic                      ctl_out_sync;
    logic                      sclk_sync;
    logic                      hshake_sync;
    wire spis_pkg::spis_sel_t  sel_sync;

    // limitation: a pin pulse shorter than one clock period may never be seen
    // readback lags the pin by two to three clock cycles
    // no reset on these flops; see the note at spis_sync2
    // sampled whatever the pin is doing, so a line driven by this device reads back too
    spis_sync2
    #(
        .WIDTH (1)
    )
    i_spis_sync2_tgt_out
    (
        .mclk_in (mclk_in),
        .d_in    (target_out_data_line_in),
        .q_out   (tgt_out_sync)
    );

    spis_sync2
    #(
        .WIDTH (1)
    )
    i_spis_sync2_ctl_out
    (
        .mclk_in (mclk_in),
        .d_in    (controller_out_data_line_in),
        .q_out   (ctl_out_sync)
    );

    spis_sync2
    #(
        .WIDTH (1)
    )
    i_spis_sync2_sclk
    (
        .mclk_in (mclk_in),
        .d_in    (serial_clock_line_in),
        .q_out   (sclk_sync)
    );

    spis_sync2
    #(
        .WIDTH (1)
    )
    i_spis_sync2_hshake
    (
        .mclk_in (mclk_in),
        .d_in    (enable_handshake_line_in),
        .q_out   (hshake_sync)
    );

    // one synchroniser per select line: the lines are unrelated, no common word is implied
    genvar sel_idx;
    generate
        for (sel_idx = 0; sel_idx < `SPIS_SEL_W; sel_idx++)
        begin : g_sel_sync
            spis_sync2
            #(
                .WIDTH (1)
            )
            i_spis_sync2_sel
            (
                .mclk_in (mclk_in),
                .d_in    (target_select_line_in[sel_idx]),
                .q_out   (sel_sync[sel_idx])
            );
        end
    endgenerate

////////////////////////////////////////////////////////////////////////////////
// register image

    // select bits of absent lines are masked here, not in the synchroniser
    wire                       tgt_out_level = tgt_out_sync;
    wire                       ctl_out_level = ctl_out_sync;
    wire                       sclk_level    = sclk_sync;
    wire                       hshake_level  = hshake_sync;
    wire spis_pkg::spis_sel_t  sel_levels    = sel_sync & `SPIS_SEL_PRESENT;
    spis_pkg::spis_word_t      level_word;

    // the word is combinational; it is registered once, in the read-data flop
    always_comb
    begin
        level_word                                = `SPIS_ZERO32;
        level_word[`SPIS_TGT_OUT_BIT]             = tgt_out_level;
        level_word[`SPIS_CTL_OUT_BIT]             = ctl_out_level;
        level_word[`SPIS_SCLK_BIT]                = sclk_level;
        level_word[`SPIS_HSHAKE_BIT]              = hshake_level;
        level_word[`SPIS_SEL_MSB:`SPIS_SEL_LSB]   = sel_levels;
    end

////////////////////////////////////////////////////////////////////////////////
// apb slave: one wait-free access phase; writes are dropped

    wire setup_phase = psel_in & ~penable_in;
    // only one word is decoded; every other address is an error
    wire hit         = (paddr_in == `SPIS_PIN_LEVELS_ADDR);
    wire rd_hit      = setup_phase & ~pwrite_in & hit;
    // a write to the read-only word or any unmapped address flags an error
    // pslverr is a local choice: a refused write is reported, not silently dropped
    wire bad_access  = setup_phase & (pwrite_in | ~hit);
    // pwdata and pstrb are not decoded: nothing in this block is writable
    // next values of the three bus outputs
    wire                       next_pready  = setup_phase;
    wire                       next_pslverr = bad_access;
    wire spis_pkg::spis_word_t next_prdata  = rd_hit ? level_word : `SPIS_ZERO32;

    // ready strobes for exactly the access-phase cycle
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pready_out <= `SPIS_ZERO1;
        end
        else
        begin
            pready_out <= next_pready;
        end
    end

    // error answer for writes and unmapped reads; it stands with ready only
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pslverr_out <= `SPIS_ZERO1;
        end
        else
        begin
            pslverr_out <= next_pslverr;
        end
    end

    // read data is zero outside a hit so the bus never sees stale levels
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            prdata_out <= `SPIS_ZERO32;
        end
        else
        begin
            prdata_out <= next_prdata;
        end
    end

endmodule // spis_pin_sampler

////////////////////////////////////////////////////////////////////////////////
// two-flop synchroniser for asynchronous pin levels
// no reset: the pin level has no defined value until it has been sampled,
// and a reset here would only hide that for two cycles
module spis_sync2
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             mclk_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    // meta may go metastable; it settles within the following period
    logic [WIDTH-1:0] meta;

    // only q_out may read meta; a second reader would see an unsettled value
    always_ff @(posedge mclk_in)
    begin
        meta  <= d_in;
        q_out <= meta;
    end

endmodule // spis_sync2

// file: design/spis_defs.svh
`ifndef SPIS_DEFS_SVH
`define SPIS_DEFS_SVH

// register byte offset on the apb window
`define SPIS_PIN_LEVELS_ADDR 12'h000
`define SPIS_ADDR_W          12

// field positions inside pin_input_levels
`define SPIS_TGT_OUT_BIT     11
`define SPIS_CTL_OUT_BIT     10
`define SPIS_SCLK_BIT        9
`define SPIS_HSHAKE_BIT      8
`define SPIS_SEL_MSB         7
`define SPIS_SEL_LSB         0
`define SPIS_SEL_W           8
`define SPIS_RSVD_W          20

// which target-select lines exist in this build
`define SPIS_SEL_PRESENT     8'hff

`define SPIS_ZERO32          32'h0000_0000
`define SPIS_ZERO1           1'h0

`endif

// file: design/spis_pkg.sv
package spis_pkg;
    typedef logic [31:0] spis_word_t;
    typedef logic [7:0]  spis_sel_t;
endpackage

// file: tb/spis_lines.sv
`timescale 1ns/1ps
module spis_lines(input wire logic [11:0] lvl_in, output logic [11:0] pins_out);
    assign pins_out = lvl_in;
endmodule // spis_lines

// file: tb/spis_pin_sampler_checker.sv
`timescale 1ns/1ps
`include "spis_defs.svh"
module spis_chk
(
    input wire logic        mclk_in,
    input wire logic        rst_b_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic        target_out_data_line_in,
    input wire logic        controller_out_data_line_in,
    input wire logic        serial_clock_line_in,
    input wire logic        enable_handshake_line_in,
    input wire logic [7:0]  target_select_line_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_setup; psel_in && !penable_in; endsequence
    sequence s_rd_hit; psel_in && !penable_in && !pwrite_in && paddr_in == `SPIS_PIN_LEVELS_ADDR; endsequence
    sequence s_bad; psel_in && !penable_in && (pwrite_in || paddr_in != `SPIS_PIN_LEVELS_ADDR); endsequence
    property p_rdy; s_setup |=> pready_out; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_one; pready_out |=> !pready_out; endproperty
    a_one: assert property (p_one) else $error("ready held");
    property p_rsv; pready_out |-> prdata_out[31:12] == 20'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_wr; s_bad |=> pslverr_out && prdata_out == 32'h0; endproperty
    a_wr: assert property (p_wr) else $error("write not refused");
    property p_hit; s_rd_hit |=> !pslverr_out; endproperty
    a_hit: assert property (p_hit) else $error("read refused");
    property p_tgt; s_rd_hit |=> prdata_out[11] == $past(target_out_data_line_in, 2); endproperty
    a_tgt: assert property (p_tgt) else $error("target-out level");
    property p_ctl; s_rd_hit |=> prdata_out[10] == $past(controller_out_data_line_in, 2); endproperty
    a_ctl: assert property (p_ctl) else $error("controller-out level");
    property p_sclk; s_rd_hit |=> prdata_out[9] == $past(serial_clock_line_in, 2); endproperty
    a_sclk: assert property (p_sclk) else $error("serial clock level");
    property p_hs; s_rd_hit |=> prdata_out[8] == $past(enable_handshake_line_in, 2); endproperty
    a_hs: assert property (p_hs) else $error("handshake level");
    property p_sel; s_rd_hit |=> prdata_out[7:0] == ($past(target_select_line_in, 2) & `SPIS_SEL_PRESENT); endproperty
    a_sel: assert property (p_sel) else $error("select levels");
endmodule // spis_chk
bind spis_pin_sampler spis_chk i_spis_chk(.mclk_in(mclk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .target_out_data_line_in(target_out_data_line_in), .controller_out_data_line_in(controller_out_data_line_in),
    .serial_clock_line_in(serial_clock_line_in), .enable_handshake_line_in(enable_handshake_line_in),
    .target_select_line_in(target_select_line_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out));

// file: tb/spis_pin_sampler_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %0t bad", $time); end end
module spis_pin_sampler_tb;
    logic        mclk_in = 0, rst_b_in = 0, psel = 0, pen = 0, pwr = 0, rdy, err;
    logic [11:0] adr = 0, lvl = 0, pins;
    logic [31:0] rd;
    logic [31:0] wd = 32'hffff_f000; // select bits written as zero
    int          n_errors = 0, comparisons = 0;
    spis_lines i_spis_lines(.lvl_in(lvl), .pins_out(pins));
    spis_pin_sampler i_spis_pin_sampler(.mclk_in(mclk_in), .rst_b_in(rst_b_in), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(adr), .pwdata_in(wd), .pstrb_in(4'hf),
        .target_out_data_line_in(pins[11]), .controller_out_data_line_in(pins[10]),
        .serial_clock_line_in(pins[9]), .enable_handshake_line_in(pins[8]), .target_select_line_in(pins[7:0]),
        .prdata_out(rd), .pready_out(rdy), .pslverr_out(err));
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] e, input logic ee);
        psel <= 1; pwr <= w; adr <= a;
        @(posedge mclk_in) pen <= 1;
        do @(posedge mclk_in); while (rdy !== 1'b1);
        `CHK({rd, err}, {e, ee})
        psel <= 0; pen <= 0;
        @(posedge mclk_in);
    endtask
    task end_sim;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial forever #10 mclk_in = ~mclk_in;
    initial
    begin
        repeat (4) @(posedge mclk_in);
        rst_b_in <= 1;
        // walking one, then all low and all high
        for (int i = 0; i < 14; i++)
        begin
            lvl <= (i < 12) ? 12'h001 << i : {12{i[0]}};
            repeat (3) @(posedge mclk_in);
            xfer(0, 12'h000, {20'h0, lvl}, 0);
        end
        xfer(1, 12'h000, 32'h0, 1);
        xfer(0, 12'h000, 32'h0000_0fff, 0);
        xfer(0, 12'h004, 32'h0, 1);
        end_sim;
    end
    initial
    begin
        #20000 n_errors++;
        end_sim;
    end
endmodule // spis_pin_sampler_tb
